// ---- design/fpu_pkg.sv ----
package fpu_pkg;

   // ------------------------------------------------------------
   // operation codes and carriers
   // ------------------------------------------------------------
   localparam logic [5:0] FN_FLOAT = 6'h3E; // function code 76 octal

   // minor codes: 00, 01, 02, 10, 11 octal
   typedef enum logic [3:0] {
      OP_FLOAT_ADD_SINGLE = 4'h0,
      OP_FLOAT_SUB_SINGLE = 4'h1,
      OP_FLOAT_MUL_SINGLE = 4'h2,
      OP_FLOAT_ADD_DOUBLE = 4'h8,
      OP_FLOAT_SUB_DOUBLE = 4'h9
   } fpu_op_t;

   // a register pair (A, A+1) or (U, U+1), hi word first
   typedef struct packed {
      logic [35:0] hi;
      logic [35:0] lo;
   } fpu_pair_t;

   // ------------------------------------------------------------
   // bit positions within the 72-bit working register
   // ------------------------------------------------------------
   localparam int W_SIGN = 71;    // sign of S or D
   localparam int W_CH_HI = 70;   // top of either characteristic
   localparam int W_CHS_LO = 63;  // single characteristic low bit
   localparam int W_CHD_LO = 60;  // double characteristic low bit
   localparam int W_FRS_HI = 62;  // single fraction, S bit 26
   localparam int W_FRD_HI = 59;  // double fraction top bit
   localparam int W_S_LO = 36;    // S bit 0, top of Q is bit 35
   localparam int W_S28 = 64;     // S bit 28
   localparam int W_S27 = 63;     // S bit 27
   localparam int W_S26 = 62;     // S bit 26
   localparam int W_D61 = 61;
   localparam int W_D60 = 60;
   localparam int W_D59 = 59;
   localparam int W_RES_LO = 9;   // residue bits are Q 35-9

   // ------------------------------------------------------------
   // characteristic arithmetic
   // ------------------------------------------------------------
   localparam logic [12:0] BIAS_S = 13'h080;    // 200 octal
   localparam logic [12:0] BIAS_S1 = 13'h081;   // 201 octal
   localparam logic [12:0] RES_OFS = 13'h01B;   // 33 octal
   localparam logic [12:0] CHAR_MAX_S = 13'h0FF;
   localparam logic [12:0] CHAR_MAX_D = 13'h7FF;
   localparam logic [6:0] NORM_MAX_S = 7'h1B;   // 33 octal
   localparam logic [6:0] NORM_MAX_D = 7'h3C;   // 74 octal
   localparam logic [6:0] SHIFT_CAP = 7'h48;    // whole register

endpackage

// ---- design/fpu_unpack.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpu_unpack
   import fpu_pkg::*;
(
   input wire fpu_pair_t word,
   input wire logic dbl,
   input wire logic inv,
   output logic neg,
   output logic [10:0] chr,
   output logic [59:0] mag,
   output logic [71:0] frac
);

   logic [71:0] raw;
   logic [71:0] pos;

   // subtract complements the whole operand first
   assign raw = inv ? ~word : word;
   assign neg = raw[W_SIGN];
   // one's complement of the whole word gives the positive form
   assign pos = neg ? ~raw : raw;
   assign chr = dbl ? pos[W_CH_HI:W_CHD_LO] :
                {3'h0, pos[W_CH_HI:W_CHS_LO]};
   assign mag = dbl ? pos[W_FRD_HI:0] :
                {33'h0, pos[W_FRS_HI:W_S_LO]};
   // one's complement fraction, right justified and sign extended
   assign frac = neg ? ~{12'h0, mag} : {12'h0, mag};

endmodule

`default_nettype wire

// ---- design/fpu_mul27.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpu_mul27 (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [26:0] mcand,
   input wire logic [26:0] mplier,
   output logic [53:0] prod_q
);

   // magnitude product, ready one cycle after load
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prod_q <= '0;
      end else if (load) begin
         prod_q <= 54'(mcand) * 54'(mplier);
      end
   end

endmodule

`default_nettype wire

// ---- design/fpu_float_unit.sv ----
// Functional notes
// - single add writes sum to A, residue A+1
// - smaller characteristic fraction to S, Q sign
// - shift S into Q by characteristic difference
// - larger fraction added to S only
// - carry into S28 shifts S,Q, bumps characteristic
// - residue repacked from Q, char less 33
// - normalize S until bit27 differs or 33
// - A gets S26-0, sign, larger characteristic
// - single subtract complements U first
// - double add aligns smaller fraction in D
// - double alignment drops shifted-out bits
// - double carry shifts D, bumps characteristic
// - normalize D until bit60 differs or 74
// - characteristic into D, D split to A,A+1
// - zero double fraction gives all zeros
// - double subtract complements U,U+1 first
// - multiply loads magnitudes, keeps product sign
// - 53-bit product shifted left one place
// - product characteristic sum less 200 or 201
// - A gets product S bits, sign, characteristic
// - A+1 gets Q bits, characteristic less 33
// - characteristic under or overflow flagged
// - negatives are one's complement of word
// - single characteristic 8 bits, bias 128
// - double characteristic 11 bits, bias 1024
`timescale 1ns/1ps
`default_nettype none

module fpu_float_unit
   import fpu_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [5:0] fn_code,
   input wire logic [3:0] minor_code,
   input wire fpu_pair_t opnd_a,
   input wire fpu_pair_t opnd_u,
   output fpu_pair_t res_q,
   output logic done_q,
   output logic underflow_q,
   output logic overflow_q,
   output logic busy_q
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ALIGN = 3'b001,
      ST_ADD = 3'b010,
      ST_CARRY = 3'b011,
      ST_NORM = 3'b100,
      ST_MULW = 3'b101,
      ST_PACK = 3'b110
   } fpu_state_t;

   fpu_state_t state_q;
   fpu_op_t op_q;
   logic [71:0] w_q;
   logic [71:0] big_q;
   logic [12:0] exp_q;
   logic [12:0] expc_q;
   logic [6:0] cnt_q;
   logic sgn_s_q;
   logic psgn_q;
   logic zero_q;

   // ---------------------------------------------------------------
   // operand decode
   // ---------------------------------------------------------------
   logic op_ok;
   logic go;
   logic is_mul;
   logic dbl_in;
   logic inv_in;
   logic neg_a;
   logic neg_u;
   logic [10:0] chr_a;
   logic [10:0] chr_u;
   logic [59:0] mag_a;
   logic [59:0] mag_u;
   logic [71:0] frac_a;
   logic [71:0] frac_u;
   logic a_small;
   logic [71:0] small_f;
   logic [10:0] diff;
   logic [53:0] prod;

   // legal minor codes only
   assign op_ok = (minor_code == OP_FLOAT_ADD_SINGLE) ||
                  (minor_code == OP_FLOAT_SUB_SINGLE) ||
                  (minor_code == OP_FLOAT_MUL_SINGLE) ||
                  (minor_code == OP_FLOAT_ADD_DOUBLE) ||
                  (minor_code == OP_FLOAT_SUB_DOUBLE);
   assign go = start && (state_q == ST_IDLE) &&
               (fn_code == FN_FLOAT) && op_ok;
   assign is_mul = (minor_code == OP_FLOAT_MUL_SINGLE);
   assign dbl_in = minor_code[3];
   assign inv_in = (minor_code == OP_FLOAT_SUB_SINGLE) ||
                   (minor_code == OP_FLOAT_SUB_DOUBLE);

   // sign-form words to signed fractions
   fpu_unpack u_unpack_a (
      .word(opnd_a),
      .dbl(dbl_in),
      .inv(1'b0),
      .neg(neg_a),
      .chr(chr_a),
      .mag(mag_a),
      .frac(frac_a)
   );

   fpu_unpack u_unpack_u (
      .word(opnd_u),
      .dbl(dbl_in),
      .inv(inv_in),
      .neg(neg_u),
      .chr(chr_u),
      .mag(mag_u),
      .frac(frac_u)
   );

   // U goes to the shifter on a tie
   assign a_small = chr_a < chr_u;
   assign small_f = a_small ? frac_a : frac_u;
   assign diff = a_small ? (chr_u - chr_a) : (chr_a - chr_u);

   // magnitude multiplier, positive-form fractions of U and A
   fpu_mul27 u_mul (
      .core_clk(core_clk),
      .reset(reset),
      .load(go && is_mul),
      .mcand(mag_u[26:0]),
      .mplier(mag_a[26:0]),
      .prod_q(prod)
   );

   // ---------------------------------------------------------------
   // status terms of the working register
   // ---------------------------------------------------------------
   logic dbl;
   logic carry;
   logic nrm;
   logic [6:0] nlim;

   assign dbl = op_q[3];
   assign carry = dbl ? (w_q[W_D61] ^ w_q[W_D60]) :
                  (w_q[W_S28] ^ w_q[W_S27]);
   assign nrm = dbl ? (w_q[W_D60] ^ w_q[W_D59]) :
                (w_q[W_S27] ^ w_q[W_S26]);
   assign nlim = dbl ? NORM_MAX_D : NORM_MAX_S;

   // one's complement sums; the carry out wraps round to bit 0
   logic [72:0] dsum;
   logic [36:0] ssum;

   assign dsum = {1'b0, w_q} + {1'b0, big_q};
   assign ssum = {1'b0, w_q[71:36]} + {1'b0, big_q[35:0]};

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         op_q <= OP_FLOAT_ADD_SINGLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (go) begin
                  op_q <= fpu_op_t'(minor_code);
                  state_q <= is_mul ? ST_MULW : ST_ALIGN;
               end
            end
            ST_ALIGN: begin
               if (cnt_q == 7'h00) begin
                  state_q <= ST_ADD;
               end
            end
            ST_ADD: state_q <= ST_CARRY;
            ST_CARRY: state_q <= ST_NORM;
            ST_NORM: begin
               if (nrm || (cnt_q == nlim)) begin
                  state_q <= ST_PACK;
               end
            end
            ST_MULW: state_q <= ST_PACK;
            ST_PACK: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // working register S:Q or D
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         w_q <= '0;
         big_q <= '0;
      end else if (go) begin
         big_q <= a_small ? frac_u : frac_a;
         if (dbl_in) begin
            w_q <= small_f;
         end else begin
            // S sign extended, Q all sign bits
            w_q <= {small_f[35:0], {36{small_f[W_SIGN]}}};
         end
      end else begin
         unique case (state_q)
            ST_ALIGN: begin
               if (cnt_q != 7'h00) begin
                  // S into Q; D drops its low bit
                  w_q <= {w_q[W_SIGN], w_q[71:1]};
               end
            end
            ST_ADD: begin
               if (dbl) begin
                  w_q <= dsum[71:0] + {71'h0, dsum[72]};
               end else begin
                  // Q stays out of the sum and keeps the residue
                  w_q[71:36] <= ssum[35:0] + {35'h0, ssum[36]};
               end
            end
            ST_CARRY: begin
               if (carry) begin
                  w_q <= {w_q[W_SIGN], w_q[71:1]};
               end
            end
            ST_NORM: begin
               if (!nrm && (cnt_q != nlim)) begin
                  if (dbl) begin
                     // sign bits fill from the right in one's complement
                     w_q <= {w_q[70:0], w_q[W_SIGN]};
                  end else begin
                     w_q[71:36] <= {w_q[70:36], w_q[W_SIGN]};
                  end
               end
            end
            ST_MULW: begin
               if (prod[53]) begin
                  w_q <= {9'h000, prod, 9'h000};
               end else begin
                  w_q <= {9'h000, prod[52:0], 10'h000};
               end
            end
            default: w_q <= w_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // characteristic and shift count
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         exp_q <= '0;
         expc_q <= '0;
         cnt_q <= '0;
      end else if (go) begin
         if (is_mul) begin
            exp_q <= {2'h0, chr_a} + {2'h0, chr_u};
         end else begin
            exp_q <= {2'h0, a_small ? chr_u : chr_a};
         end
         cnt_q <= (diff > {4'h0, SHIFT_CAP}) ? SHIFT_CAP : diff[6:0];
      end else begin
         unique case (state_q)
            ST_ALIGN: begin
               if (cnt_q != 7'h00) begin
                  cnt_q <= cnt_q - 7'h01;
               end
            end
            ST_CARRY: begin
               exp_q <= exp_q + {12'h000, carry};
               expc_q <= exp_q + {12'h000, carry};
               cnt_q <= 7'h00;
            end
            ST_NORM: begin
               if (!nrm && (cnt_q != nlim)) begin
                  exp_q <= exp_q - 13'h0001;
                  cnt_q <= cnt_q + 7'h01;
               end
            end
            ST_MULW: begin
               exp_q <= exp_q - (prod[53] ? BIAS_S : BIAS_S1);
            end
            default: cnt_q <= cnt_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // signs and zero detect
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sgn_s_q <= 1'b0;
         psgn_q <= 1'b0;
         zero_q <= 1'b0;
      end else if (go) begin
         sgn_s_q <= small_f[W_SIGN];
         psgn_q <= neg_a ^ neg_u;
         zero_q <= 1'b0;
      end else if ((state_q == ST_NORM) && !nrm && (cnt_q == nlim)) begin
         zero_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // result packing
   // ---------------------------------------------------------------
   logic [35:0] s_mag;
   logic [71:0] d_mag;
   logic [12:0] rexp;
   logic [7:0] rch;
   logic [35:0] pk_a;
   logic [35:0] pk_a1;
   logic [71:0] pk_d;
   logic [12:0] clim;

   assign s_mag = w_q[W_SIGN] ? ~w_q[71:36] : w_q[71:36];
   assign d_mag = w_q[W_SIGN] ? ~w_q : w_q;
   assign rexp = (op_q == OP_FLOAT_MUL_SINGLE ? exp_q : expc_q) - RES_OFS;
   assign rch = rexp[7:0];
   assign clim = dbl ? CHAR_MAX_D : CHAR_MAX_S;

   // sign form is the complement of the positive word
   always_comb begin
      pk_d = {1'b0, exp_q[10:0], d_mag[W_FRD_HI:0]}
             ^ {72{w_q[W_SIGN]}};
      if (op_q == OP_FLOAT_MUL_SINGLE) begin
         pk_a = {1'b0, exp_q[7:0], w_q[W_FRS_HI:W_S_LO]}
                ^ {36{psgn_q}};
         pk_a1 = {1'b0, rch, w_q[35:W_RES_LO]}
                 ^ {36{psgn_q}};
      end else begin
         pk_a = {1'b0, exp_q[7:0], s_mag[26:0]}
                ^ {36{w_q[W_SIGN]}};
         pk_a1 = {sgn_s_q, sgn_s_q ? ~rch : rch,
                  w_q[35:W_RES_LO]};
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         res_q <= '0;
         done_q <= 1'b0;
         underflow_q <= 1'b0;
         overflow_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         done_q <= (state_q == ST_PACK);
         busy_q <= go || (busy_q && (state_q != ST_PACK));
         underflow_q <= 1'b0;
         overflow_q <= 1'b0;
         if (state_q == ST_PACK) begin
            if (dbl && zero_q) begin
               res_q <= '0;
            end else begin
               if (dbl) begin
                  res_q <= pk_d;
               end else begin
                  res_q <= {pk_a, pk_a1};
               end
               underflow_q <= exp_q[12];
               overflow_q <= !exp_q[12] && (exp_q > clim);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   property p_align_shift;
      (state_q == ST_ALIGN) && (cnt_q != 7'h00) |=>
         (w_q[70:0] == $past(w_q[71:1])) && (cnt_q == $past(cnt_q) - 7'h01);
   endproperty
   a_align_shift: assert property (p_align_shift)
      else $error("alignment shift wrong");

   property p_carry_s;
      (state_q == ST_CARRY) && !dbl && (w_q[W_S28] ^ w_q[W_S27]) |=>
         (exp_q == $past(exp_q) + 13'h0001) && !(w_q[W_S28] ^ w_q[W_S27]);
   endproperty
   a_carry_s: assert property (p_carry_s)
      else $error("single carry not corrected");

   property p_carry_d;
      (state_q == ST_CARRY) && dbl && (w_q[W_D61] ^ w_q[W_D60]) |=>
         exp_q == $past(exp_q) + 13'h0001;
   endproperty
   a_carry_d: assert property (p_carry_d)
      else $error("double carry not corrected");

   property p_norm_s;
      (state_q == ST_NORM) && !dbl && (w_q[W_S27] != w_q[W_S26]) |=>
         (state_q == ST_PACK) ##1 done_q;
   endproperty
   a_norm_s: assert property (p_norm_s)
      else $error("normalized single sum not packed");

   property p_norm_lim_d;
      (state_q == ST_NORM) && dbl && (cnt_q == NORM_MAX_D) |=>
         (state_q == ST_PACK) && zero_q;
   endproperty
   a_norm_lim_d: assert property (p_norm_lim_d)
      else $error("double zero limit missed");

   property p_dzero;
      done_q && dbl && zero_q |-> (res_q == '0) && !overflow_q;
   endproperty
   a_dzero: assert property (p_dzero)
      else $error("zero double result not cleared");

   property p_mul_seq;
      go && is_mul |=> (state_q == ST_MULW) ##1 (state_q == ST_PACK)
         ##1 done_q;
   endproperty
   a_mul_seq: assert property (p_mul_seq)
      else $error("multiply sequence broken");

   property p_done_bound;
      go |-> ##[3:160] done_q;
   endproperty
   a_done_bound: assert property (p_done_bound)
      else $error("operation did not finish");

   property p_flags_with_done;
      (overflow_q || underflow_q) |-> done_q && !busy_q;
   endproperty
   a_flags_with_done: assert property (p_flags_with_done)
      else $error("flag outside result write");

   property p_ovf_cause;
      (state_q == ST_PACK) && !(dbl && zero_q) && !exp_q[12] &&
         (exp_q > clim) |=> overflow_q;
   endproperty
   a_ovf_cause: assert property (p_ovf_cause)
      else $error("overflow not flagged");

   c_add_single: cover property (go && (minor_code == OP_FLOAT_ADD_SINGLE));
   c_mul_single: cover property ((state_q == ST_MULW) && !prod[53]);
   c_dbl_zero: cover property (done_q && dbl && zero_q);
   c_overflow: cover property (overflow_q);

endmodule

`default_nettype wire

// ---- tb/fpu_fetch_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpu_fetch_model
   import fpu_pkg::*;
(
   input wire logic core_clk,
   input wire logic busy_q,
   output logic start,
   output logic [5:0] fn_code,
   output logic [3:0] minor_code,
   output var fpu_pair_t opnd_a,
   output var fpu_pair_t opnd_u
);
   // ------------------------------------------------------------
   // operand fetch side of the float unit
   // ------------------------------------------------------------

   // idle request lines at time zero
   initial begin
      start = 1'b0;
      fn_code = 6'h00;
      minor_code = 4'h0;
      opnd_a = '0;
      opnd_u = '0;
   end

   // one request cycle from a falling edge, no busy check
   task automatic poke(input logic [5:0] fn, input logic [3:0] op,
      input fpu_pair_t a, input fpu_pair_t u);
      start = 1'b1;
      fn_code = fn;
      minor_code = op;
      opnd_a = a;
      opnd_u = u;
      @(negedge core_clk);
      // operands only count at the taking edge, so scramble them
      start = 1'b0;
      fn_code = ~fn;
      minor_code = ~op;
      opnd_a = ~a;
      opnd_u = ~u;
   endtask

   // wait for an idle unit, then make the request
   task automatic issue(input logic [5:0] fn, input logic [3:0] op,
      input fpu_pair_t a, input fpu_pair_t u, output logic stuck);
      int n;
      n = 0;
      while (busy_q !== 1'b0 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      stuck = (busy_q !== 1'b0);
      poke(fn, op, a, u);
   endtask
endmodule

`default_nettype wire

// ---- tb/float_add_sub_multiply_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module float_add_sub_multiply_unit_tb
   import fpu_pkg::*;
;
   // ------------------------------------------------------------
   // bench signals and operands
   // ------------------------------------------------------------
   localparam fpu_pair_t DA = 72'h40268E977FBA72EE0A;
   localparam fpu_pair_t DU = 72'hC008D4BF121395A25C;
   localparam fpu_pair_t DR = 72'h401B525EC3F9CB44AC;
   logic core_clk, reset, start, done_q, underflow_q, overflow_q, busy_q;
   logic [5:0] fn_code;
   logic [3:0] minor_code;
   fpu_pair_t opnd_a, opnd_u, res_q;
   int miscompares = 0;
   int n_checks = 0;

   fpu_float_unit uut (.core_clk(core_clk), .reset(reset),
      .start(start), .fn_code(fn_code), .minor_code(minor_code),
      .opnd_a(opnd_a), .opnd_u(opnd_u), .res_q(res_q),
      .done_q(done_q), .underflow_q(underflow_q),
      .overflow_q(overflow_q), .busy_q(busy_q));

   fpu_fetch_model fetch (.core_clk(core_clk), .busy_q(busy_q),
      .start(start), .fn_code(fn_code), .minor_code(minor_code),
      .opnd_a(opnd_a), .opnd_u(opnd_u));

   // 200 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [71:0] exp,
      input logic [71:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // bounded wait for the completion pulse, counted in cycles
   task automatic wait_done(output int n);
      n = 0;
      while (done_q !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      if (done_q !== 1'b1) begin
         miscompares++;
         $display("[ERR] done_q expected 1 seen %b", done_q);
         final_report();
      end
   endtask

   task automatic op_run(input fpu_op_t op, input fpu_pair_t a,
      input fpu_pair_t u, output int n);
      logic stuck;
      fetch.issue(FN_FLOAT, op, a, u, stuck);
      check("issue_wait", 72'h0, {71'h0, stuck});
      if (stuck) begin
         final_report();
      end
      wait_done(n);
   endtask

   // result words and both flags in the done cycle
   task automatic res_ok(input string name, input fpu_pair_t exp,
      input logic [1:0] fl);
      check(name, exp, res_q);
      check("flags", {70'h0, fl}, {70'h0, overflow_q, underflow_q});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      check("rst_res", 72'h0, res_q);
      check("rst_out", 72'h0, {68'h0, done_q, busy_q, overflow_q,
         underflow_q});
   endtask

   task automatic t_add_single;
      int n;
      op_run(OP_FLOAT_ADD_SINGLE, {36'h5A44E5DD2, 36'hA5BB1A22D},
         {36'h546CEC689, 36'hAB9313976}, n);
      res_ok("fa_res", {36'h5A44ECABE, 36'h4CB448000}, 2'h0);
   endtask

   // subtract example, then subtract of a complemented addend
   task automatic t_sub_single;
      int n;
      op_run(OP_FLOAT_SUB_SINGLE, {36'h5EEC00009, 36'h0},
         {36'h544400002, 36'h0}, n);
      res_ok("fan_res", {36'h5EEBFFFE7, 36'hAEFFFFF7F}, 2'h0);
      op_run(OP_FLOAT_SUB_SINGLE, {36'h5A44E5DD2, 36'h0},
         {~36'h546CEC689, 36'h0}, n);
      res_ok("fan_neg", {36'h5A44ECABE, 36'h4CB448000}, 2'h0);
   endtask

   // latency, one-cycle pulse, and a request refused while busy
   task automatic t_mul;
      int n;
      logic stuck;
      fpu_pair_t a, u;
      a = {36'h44EB1A201, 36'h0};
      u = {36'h3D6A25825, 36'h0};
      op_run(OP_FLOAT_MUL_SINGLE, a, u, n);
      check("mul_lat", 72'h2, 72'(n));
      res_ok("fm_res", {36'h41D8D1052, 36'h341FEC225}, 2'h0);
      @(negedge core_clk);
      check("done_drop", 72'h0, {70'h0, done_q, busy_q});
      fetch.issue(FN_FLOAT, OP_FLOAT_MUL_SINGLE, a, u, stuck);
      check("issue_wait2", 72'h0, {71'h0, stuck});
      check("mul_busy", 72'h1, {71'h0, busy_q});
      fetch.poke(FN_FLOAT, OP_FLOAT_ADD_DOUBLE, u, a);
      wait_done(n);
      res_ok("fm_keep", {36'h41D8D1052, 36'h341FEC225}, 2'h0);
   endtask

   task automatic t_double;
      int n;
      op_run(OP_FLOAT_ADD_DOUBLE, DA, DU, n);
      res_ok("dfa_res", DR, 2'h0);
      op_run(OP_FLOAT_SUB_DOUBLE, DA, ~DU, n);
      res_ok("dfs_res", DR, 2'h0);
      op_run(OP_FLOAT_SUB_DOUBLE, DA, DA, n);
      res_ok("dzero", 72'h0, 2'h0);
   endtask

   // bad function code and unused minor code start nothing
   task automatic t_refuse;
      int bad;
      bad = 0;
      fetch.poke(6'h3D, OP_FLOAT_ADD_SINGLE, DA, DU);
      fetch.poke(FN_FLOAT, 4'h3, DA, DU);
      repeat (20) begin
         @(negedge core_clk);
         if (done_q !== 1'b0 || busy_q !== 1'b0) begin
            bad++;
         end
      end
      check("refused", 72'h0, 72'(bad));
      check("res_hold", 72'h0, res_q);
   endtask

   // characteristic out of range on both ends
   task automatic t_flags;
      int n;
      op_run(OP_FLOAT_MUL_SINGLE, {36'h7FC000000, 36'h0},
         {36'h7FC000000, 36'h0}, n);
      check("ovf", 72'h2, {70'h0, overflow_q, underflow_q});
      op_run(OP_FLOAT_MUL_SINGLE, {36'h004000000, 36'h0},
         {36'h004000000, 36'h0}, n);
      check("unf", 72'h1, {70'h0, overflow_q, underflow_q});
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      repeat (10) @(negedge core_clk);
      reset = 1'b0;
      @(negedge core_clk);
      t_reset();
      t_add_single();
      t_sub_single();
      t_mul();
      t_double();
      t_refuse();
      t_flags();
      final_report();
   end
endmodule

`default_nettype wire
